// file: src/lrx_status_bank.sv
// receive line status, latched events, interrupt enables and counters
// assumes decoder event pulses on clock_in, loss detector level from outside
// Functional notes
// - zero-run flag bit 3 means count nonzero
// - violation flag bit 1 means count nonzero
// - live bit 0 shows loss of signal
// - signature detection sets latched bit 5 unless decode is disabled
// - excessive-zero event sets latched bit 4
// - zero-run flag rising edge sets bit 3
// - bipolar violation, or instead E3 coding violation when E3 select applies off B3ZS, sets bit 2
// - violation flag rising edge sets bit 1
// - any loss-of-signal change sets bit 0
// - decode disabled forces loss of signal off
// - enable bits mirror latched bit positions
// - interrupt needs latched, enabled and port enable
// - all interrupt enables reset to zero
// - violation count register snapshots on update strobe
// - E3 select counts coding violations, not B3ZS
// - decode-off bit selects plain AMI decoding
`timescale 1ns/1ns
`default_nettype none
module lrx_status_bank
    import lrx_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [LRX_ADDR_W-1:0] reg_addr_in,
    input wire logic [LRX_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [LRX_DATA_W-1:0] reg_rdata_out,
    input wire logic signal_loss_raw_in,
    input wire logic signature_detect_in,
    input wire logic zero_run_event_in,
    input wire logic bipolar_violation_in,
    input wire logic e3_coding_violation_in,
    input wire logic b3zs_mode_in,
    input wire logic perf_monitor_update_strobe_in,
    input wire logic port_status_irq_enable_in,
    output logic rx_substitution_decode_off_out,
    output logic e3_code_violation_select_out,
    output logic irq_out
);
    lrx_cnt_if viol_cnt ();
    lrx_cnt_if zero_cnt ();

    logic rx_substitution_decode_off;
    logic e3_code_violation_select;
    logic signal_loss_sync;
    logic signal_loss;
    logic signal_loss_prev;
    logic zero_run_count_nonzero;
    logic violation_count_nonzero;
    logic zero_nz_prev;
    logic viol_nz_prev;
    logic [LRX_EVT_W-1:0] latched;
    logic [LRX_EVT_W-1:0] irq_en;
    logic [LRX_EVT_W-1:0] next_set;
    logic [LRX_EVT_W-1:0] clear_mask;
    logic [LRX_DATA_W-1:0] next_rdata;
    logic [LRX_DATA_W-1:0] live_word;
    logic [LRX_DATA_W-1:0] control_word;
    logic e3_counting;
    logic violation_event;
    logic signature_event;
    logic wr_control;
    logic wr_latched;
    logic wr_irq_en;

    // write decode
    always_comb
    begin
        wr_control = 1'b0;
        wr_latched = 1'b0;
        wr_irq_en = 1'b0;
        if (reg_write_in)
        begin
            if (reg_addr_in == LRX_OFS_CONTROL)
                wr_control = 1'b1;
            else if (reg_addr_in == LRX_OFS_LATCHED)
                wr_latched = 1'b1;
            else if (reg_addr_in == LRX_OFS_IRQ_EN)
                wr_irq_en = 1'b1;
        end
    end

    // control register
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rx_substitution_decode_off <= 1'b0;
            e3_code_violation_select <= 1'b0;
        end
        else if (wr_control)
        begin
            rx_substitution_decode_off <= reg_wdata_in[LRX_CTL_DECODE_OFF];
            e3_code_violation_select <= reg_wdata_in[LRX_CTL_E3_SEL];
        end
    end

    // decoder controls leave straight from flops
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rx_substitution_decode_off_out <= 1'b0;
            e3_code_violation_select_out <= 1'b0;
        end
        else
        begin
            rx_substitution_decode_off_out <= rx_substitution_decode_off;
            e3_code_violation_select_out <= e3_code_violation_select;
        end
    end

    // loss detector sits outside this clock domain
    lrx_sync3 u_loss_sync (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .level_in(signal_loss_raw_in),
        .level_out(signal_loss_sync)
    );

    // loss of signal cannot exist while substitution decoding is off
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            signal_loss <= 1'b0;
        else if (rx_substitution_decode_off)
            signal_loss <= 1'b0;
        else
            signal_loss <= signal_loss_sync;
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            signal_loss_prev <= 1'b0;
        else
            signal_loss_prev <= signal_loss;
    end

    // E3 selection has no meaning on a B3ZS line
    assign e3_counting = e3_code_violation_select && !b3zs_mode_in;
    assign violation_event = e3_counting ? e3_coding_violation_in : bipolar_violation_in;
    // a decoder in plain AMI mode has no signatures to report
    assign signature_event = signature_detect_in && !rx_substitution_decode_off;

    assign viol_cnt.event_pulse = violation_event;
    assign viol_cnt.snapshot = perf_monitor_update_strobe_in;
    assign zero_cnt.event_pulse = zero_run_event_in;
    assign zero_cnt.snapshot = perf_monitor_update_strobe_in;

    lrx_event_counter u_viol_counter (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .cnt(viol_cnt)
    );

    lrx_event_counter u_zero_counter (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .cnt(zero_cnt)
    );

    // flags come from the running counts, so an update drops them unless an event falls in the strobe cycle
    assign zero_run_count_nonzero = zero_cnt.nonzero;
    assign violation_count_nonzero = viol_cnt.nonzero;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            zero_nz_prev <= 1'b0;
            viol_nz_prev <= 1'b0;
        end
        else
        begin
            zero_nz_prev <= zero_run_count_nonzero;
            viol_nz_prev <= violation_count_nonzero;
        end
    end

    // event set vector in the latched layout
    always_comb
    begin
        next_set = LRX_RST_EVT;
        next_set[LRX_EVT_SIG] = signature_event;
        next_set[LRX_EVT_ZERO] = zero_run_event_in;
        next_set[LRX_EVT_ZERO_NZ] = zero_run_count_nonzero && !zero_nz_prev;
        next_set[LRX_EVT_VIOL] = violation_event;
        next_set[LRX_EVT_VIOL_NZ] = violation_count_nonzero && !viol_nz_prev;
        next_set[LRX_EVT_LOSS_CHG] = signal_loss != signal_loss_prev;
    end

    assign clear_mask = wr_latched ? reg_wdata_in[LRX_EVT_W-1:0] : LRX_RST_EVT;

    // a set in the clear cycle survives the clear
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            latched <= LRX_RST_EVT;
        else
            latched <= (latched & ~clear_mask) | next_set;
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            irq_en <= LRX_RST_EVT;
        else if (wr_irq_en)
            irq_en <= reg_wdata_in[LRX_EVT_W-1:0];
    end

    // registered request: follows the enabled latched bits one clock later
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            irq_out <= 1'b0;
        else
            irq_out <= (|(latched & irq_en)) && port_status_irq_enable_in;
    end

    // read words
    always_comb
    begin
        live_word = LRX_RST_WORD;
        live_word[LRX_LIVE_LOSS] = signal_loss;
        live_word[LRX_LIVE_VIOL_NZ] = violation_count_nonzero;
        live_word[LRX_LIVE_ZERO_NZ] = zero_run_count_nonzero;
    end

    always_comb
    begin
        control_word = LRX_RST_WORD;
        control_word[LRX_CTL_DECODE_OFF] = rx_substitution_decode_off;
        control_word[LRX_CTL_E3_SEL] = e3_code_violation_select;
    end

    // read decode; unmapped addresses read zero
    always_comb
    begin
        next_rdata = LRX_RST_WORD;
        if (reg_addr_in == LRX_OFS_CONTROL)
            next_rdata = control_word;
        else if (reg_addr_in == LRX_OFS_LIVE)
            next_rdata = live_word;
        else if (reg_addr_in == LRX_OFS_LATCHED)
            next_rdata = {{(LRX_DATA_W-LRX_EVT_W){1'b0}}, latched};
        else if (reg_addr_in == LRX_OFS_IRQ_EN)
            next_rdata = {{(LRX_DATA_W-LRX_EVT_W){1'b0}}, irq_en};
        else if (reg_addr_in == LRX_OFS_VIOL_CNT)
            next_rdata = viol_cnt.held_count;
        else if (reg_addr_in == LRX_OFS_ZERO_CNT)
            next_rdata = zero_cnt.held_count;
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            reg_rdata_out <= LRX_RST_WORD;
        else if (reg_read_in)
            reg_rdata_out <= next_rdata;
        else
            reg_rdata_out <= LRX_RST_WORD;
    end
endmodule : lrx_status_bank
`default_nettype wire

// file: src/lrx_pkg.sv
// package for the line receive status and interrupt register bank
// assumes one 100 MHz clock and a plain strobe register port
package lrx_pkg;
    localparam int unsigned LRX_ADDR_W = 8;
    localparam int unsigned LRX_DATA_W = 16;
    localparam int unsigned LRX_CNT_W = 16;
    localparam int unsigned LRX_EVT_W = 6;

    // register offsets, byte addresses as printed
    localparam logic [LRX_ADDR_W-1:0] LRX_OFS_CONTROL = 8'h90;
    localparam logic [LRX_ADDR_W-1:0] LRX_OFS_LIVE = 8'h94;
    localparam logic [LRX_ADDR_W-1:0] LRX_OFS_LATCHED = 8'h96;
    localparam logic [LRX_ADDR_W-1:0] LRX_OFS_IRQ_EN = 8'h98;
    localparam logic [LRX_ADDR_W-1:0] LRX_OFS_VIOL_CNT = 8'h9c;
    localparam logic [LRX_ADDR_W-1:0] LRX_OFS_ZERO_CNT = 8'h9e;

    // control register fields
    localparam int unsigned LRX_CTL_DECODE_OFF = 0;
    localparam int unsigned LRX_CTL_E3_SEL = 3;

    // live status fields
    localparam int unsigned LRX_LIVE_LOSS = 0;
    localparam int unsigned LRX_LIVE_VIOL_NZ = 1;
    localparam int unsigned LRX_LIVE_ZERO_NZ = 3;

    // latched status and enable fields share one layout
    localparam int unsigned LRX_EVT_LOSS_CHG = 0;
    localparam int unsigned LRX_EVT_VIOL_NZ = 1;
    localparam int unsigned LRX_EVT_VIOL = 2;
    localparam int unsigned LRX_EVT_ZERO_NZ = 3;
    localparam int unsigned LRX_EVT_ZERO = 4;
    localparam int unsigned LRX_EVT_SIG = 5;

    // reset values and counter constants
    localparam logic [LRX_DATA_W-1:0] LRX_RST_WORD = 16'h0000;
    localparam logic [LRX_EVT_W-1:0] LRX_RST_EVT = 6'h00;
    localparam logic [LRX_CNT_W-1:0] LRX_CNT_ZERO = 16'h0000;
    localparam logic [LRX_CNT_W-1:0] LRX_CNT_ONE = 16'h0001;
    localparam logic [LRX_CNT_W-1:0] LRX_CNT_MAX = 16'hffff;
endpackage : lrx_pkg

// file: src/lrx_cnt_if.sv
// bundle between the register bank and one event counter
// assumes counter and user share clock_in
`timescale 1ns/1ns
`default_nettype none
interface lrx_cnt_if
    import lrx_pkg::*;
();
    logic event_pulse;
    logic snapshot;
    logic [LRX_CNT_W-1:0] held_count;
    logic nonzero;

    modport counter (input event_pulse, input snapshot, output held_count, output nonzero);
    modport user (output event_pulse, output snapshot, input held_count, input nonzero);
endinterface : lrx_cnt_if
`default_nettype wire

// file: src/lrx_sync3.sv
// three-stage synchroniser for one level from outside the clock domain
// assumes a level that stays put for at least three clocks
`timescale 1ns/1ns
`default_nettype none
module lrx_sync3
    import lrx_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic level_in,
    output logic level_out
);
    logic stage_a;
    logic stage_b;
    logic stage_c;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            stage_a <= 1'b0;
            stage_b <= 1'b0;
            stage_c <= 1'b0;
        end
        else
        begin
            stage_a <= level_in;
            stage_b <= stage_a;
            stage_c <= stage_b;
        end
    end

    // accept a change only once the last two stages agree
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            level_out <= 1'b0;
        else if (stage_b == stage_c)
            level_out <= stage_c;
    end
endmodule : lrx_sync3
`default_nettype wire

// file: src/lrx_event_counter.sv
// saturating event counter with snapshot on the monitoring update strobe
// assumes event pulses are one clock wide and on clock_in
`timescale 1ns/1ns
`default_nettype none
module lrx_event_counter
    import lrx_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    lrx_cnt_if.counter cnt
);
    logic [LRX_CNT_W-1:0] running;

    // an event in the snapshot cycle starts the next interval, so none is lost
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            running <= LRX_CNT_ZERO;
        else if (cnt.snapshot)
            running <= cnt.event_pulse ? LRX_CNT_ONE : LRX_CNT_ZERO;
        else if (cnt.event_pulse && running != LRX_CNT_MAX)
            running <= running + LRX_CNT_ONE;
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            cnt.held_count <= LRX_CNT_ZERO;
        else if (cnt.snapshot)
            cnt.held_count <= running;
    end

    assign cnt.nonzero = (running != LRX_CNT_ZERO);
endmodule : lrx_event_counter
`default_nettype wire

// file: tb/lrx_status_bank_properties.sv
// port checker for the receive status bank
// assumes binding to every lrx_status_bank instance
`timescale 1ns/1ns
`default_nettype none
module lrx_status_bank_properties
    import lrx_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [LRX_ADDR_W-1:0] reg_addr_in,
    input wire logic [LRX_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [LRX_DATA_W-1:0] reg_rdata_out,
    input wire logic signature_detect_in,
    input wire logic zero_run_event_in,
    input wire logic bipolar_violation_in,
    input wire logic b3zs_mode_in,
    input wire logic port_status_irq_enable_in,
    input wire logic rx_substitution_decode_off_out,
    input wire logic irq_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    wire logic rl = reg_read_in && reg_addr_in == LRX_OFS_LATCHED;
    wire logic re = reg_read_in && reg_addr_in == LRX_OFS_IRQ_EN;
    wire logic off0 = reg_wdata_in[LRX_CTL_DECODE_OFF];
    // decode-off seen through its one-clock-late copy
    a_sig_latch: assert property (signature_detect_in ##1 rl && !rx_substitution_decode_off_out
        |=> reg_rdata_out[LRX_EVT_SIG]) else $error("signature not latched");
    a_zero_latch: assert property (zero_run_event_in ##1 rl
        |=> reg_rdata_out[LRX_EVT_ZERO]) else $error("zero run not latched");
    a_viol_latch: assert property (bipolar_violation_in && b3zs_mode_in ##1 rl
        |=> reg_rdata_out[LRX_EVT_VIOL]) else $error("violation not latched");
    a_clear_one: assert property (reg_write_in && reg_addr_in == LRX_OFS_LATCHED
        && reg_wdata_in[LRX_EVT_ZERO] && !zero_run_event_in ##1 rl
        |=> !reg_rdata_out[LRX_EVT_ZERO]) else $error("latched bit not cleared");
    a_port_gate: assert property (!port_status_irq_enable_in |=> !irq_out) else $error("irq without port enable");
    a_enable_rw: assert property (reg_write_in && reg_addr_in == LRX_OFS_IRQ_EN ##1 re
        |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h003f)) else $error("enable readback");
    a_enable_reset: assert property (disable iff (1'b0) rst_in ##1 re
        |=> reg_rdata_out == LRX_RST_WORD) else $error("enable not zero after reset");
    a_decode_off: assert property (reg_write_in && reg_addr_in == LRX_OFS_CONTROL
        |=> ##1 rx_substitution_decode_off_out == $past(off0, 2)) else $error("decode-off copy");
endmodule : lrx_status_bank_properties
bind lrx_status_bank lrx_status_bank_properties chk (.clock_in(clock_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .signature_detect_in(signature_detect_in),
    .zero_run_event_in(zero_run_event_in), .bipolar_violation_in(bipolar_violation_in),
    .b3zs_mode_in(b3zs_mode_in), .port_status_irq_enable_in(port_status_irq_enable_in),
    .rx_substitution_decode_off_out(rx_substitution_decode_off_out), .irq_out(irq_out));
`default_nettype wire

// file: tb/lrx_status_bank_test.sv
// self-checking bench for the receive status bank
// assumes 100 MHz clock_in and the package offsets
`timescale 1ns/1ns
`default_nettype none
module lrx_status_bank_test
    import lrx_pkg::*;
();
    logic clk = 0, rst = 1, wr = 0, rd = 0, los = 0, b3 = 1, perf_monitor_update_strobe = 0, pe = 0;
    logic [3:0] ev = 0;
    logic [7:0] a = 0;
    logic [15:0] wd = 0, q, r;
    logic dof, e3s, irq;
    int n_errors = 0, total_checks = 0, lat = 0, en = 0, ctl = 0, vn = 0, zn = 0, vh = 0, zh = 0, ls = 0;
    lrx_status_bank uut (.clock_in(clk), .rst_in(rst), .reg_addr_in(a), .reg_wdata_in(wd), .reg_write_in(wr),
        .reg_read_in(rd), .reg_rdata_out(q), .signal_loss_raw_in(los), .signature_detect_in(ev[0]),
        .zero_run_event_in(ev[1]), .bipolar_violation_in(ev[2]), .e3_coding_violation_in(ev[3]),
        .b3zs_mode_in(b3), .perf_monitor_update_strobe_in(perf_monitor_update_strobe), .port_status_irq_enable_in(pe),
        .rx_substitution_decode_off_out(dof), .e3_code_violation_select_out(e3s), .irq_out(irq));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input int exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic int regv(input logic [7:0] ad);
        case (ad)
            LRX_OFS_CONTROL: return ctl & 9;
            LRX_OFS_LIVE: return (zn != 0) * 8 + (vn != 0) * 2 + ls;
            LRX_OFS_LATCHED: return lat;
            LRX_OFS_IRQ_EN: return en;
            LRX_OFS_VIOL_CNT: return vh;
            LRX_OFS_ZERO_CNT: return zh;
            default: return 0;
        endcase
    endfunction : regv
    // write, read, or write then read at once
    task automatic bus(input logic w, input logic [7:0] ad, input logic [15:0] d, input logic rr);
        @(posedge clk);
        a <= ad;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 0;
        rd <= w & rr;
        if (w && ad == LRX_OFS_IRQ_EN)
            en = d & 16'h3f;
        if (w && ad == LRX_OFS_LATCHED)
            lat = lat & ~int'(d);
        if (w && ad == LRX_OFS_CONTROL)
            ctl = d;
        if (w & rr)
        begin
            @(posedge clk);
            rd <= 0;
        end
        if (rr)
            #1 chk(q, regv(ad));
    endtask : bus
    // event pulse followed at once by a latched read; count-rise bits land a clock later
    task automatic pulse(input int k);
        int rise;
        rise = 0;
        @(posedge clk);
        ev <= 4'h1 << k;
        @(posedge clk);
        ev <= 0;
        rd <= 1;
        a <= LRX_OFS_LATCHED;
        if (k == 0 && !ctl[0])
            lat |= 32;
        if (k == 1)
        begin
            lat |= 16;
            rise = (zn == 0) ? 8 : 0;
            zn++;
        end
        if ((k == 2 && !(ctl[3] && !b3)) || (k == 3 && ctl[3] && !b3))
        begin
            lat |= 4;
            rise = (vn == 0) ? 2 : 0;
            vn++;
        end
        @(posedge clk);
        rd <= 0;
        #1 chk(q, lat);
        lat |= rise;
    endtask : pulse
    task automatic strobe();
        @(posedge clk);
        perf_monitor_update_strobe <= 1;
        @(posedge clk);
        perf_monitor_update_strobe <= 0;
        vh = vn;
        zh = zn;
        vn = 0;
        zn = 0;
    endtask : strobe
    // loss path has a synchroniser, so wait well past it
    task automatic settle();
        repeat (8) @(posedge clk);
        if ((los && !ctl[0]) != ls)
            lat |= 1;
        ls = los && !ctl[0];
    endtask : settle
    task automatic ci();
        repeat (3) @(posedge clk);
        #1 chk({15'h0, irq}, ((lat & en) != 0) && pe);
    endtask : ci
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial
    begin
        #400000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'hf6eb3626));
        repeat (10) @(posedge clk);
        rst <= 0;
        rd <= 1;
        a <= LRX_OFS_IRQ_EN;
        @(posedge clk);
        rd <= 0;
        #1 chk(q, 0);
        bus(0, LRX_OFS_LATCHED, 0, 1);
        bus(0, 8'h92, 0, 1);
        r = 16'($urandom);
        bus(1, LRX_OFS_IRQ_EN, r, 1);
        for (int i = 0; i < 2; i++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                pulse(k);
                pulse(k);
                bus(0, LRX_OFS_LIVE, 0, 1);
                r = 16'($urandom);
                bus(1, LRX_OFS_LATCHED, r, 1);
                ci();
            end
            strobe();
            bus(1, LRX_OFS_VIOL_CNT, 16'hffff, 1);
            bus(0, LRX_OFS_ZERO_CNT, 0, 1);
            bus(0, LRX_OFS_LIVE, 0, 1);
        end
        bus(1, LRX_OFS_CONTROL, 16'h0008, 1);
        @(posedge clk);
        b3 <= 0;
        #1 chk({15'h0, e3s}, 1);
        pulse(3);
        pulse(2);
        @(posedge clk);
        b3 <= 1;
        pulse(3);
        strobe();
        bus(0, LRX_OFS_VIOL_CNT, 0, 1);
        bus(1, LRX_OFS_LATCHED, 16'hffff, 1);
        @(posedge clk);
        los <= 1;
        settle();
        bus(0, LRX_OFS_LIVE, 0, 1);
        bus(1, LRX_OFS_IRQ_EN, 16'h0001, 1);
        @(posedge clk);
        pe <= 1;
        ci();
        bus(1, LRX_OFS_LATCHED, 16'h0001, 1);
        bus(1, LRX_OFS_CONTROL, 16'h0001, 0);
        settle();
        chk({15'h0, dof}, 1);
        bus(0, LRX_OFS_LIVE, 0, 1);
        pulse(0);
        bus(1, LRX_OFS_IRQ_EN, 16'h0004, 1);
        pulse(2);
        ci();
        @(posedge clk);
        pe <= 0;
        ci();
        bus(1, LRX_OFS_CONTROL, 16'h0000, 0);
        settle();
        bus(0, LRX_OFS_LATCHED, 0, 1);
        end_sim();
    end
endmodule : lrx_status_bank_test
`default_nettype wire
